// *** logic/dsac_ctrl.sv ***
// Control sequencer for a 24-bit delta-sigma converter.
// Assumes control bits and the result-ready handshake come from system-clock logic;
// the analog modulator bit is a pin and is synchronised here.
//
// How it works
// RQ1 - Software clears power-off and sleep before converting.
// RQ2 - A low-high-low pulse on filter reset starts a conversion.
// RQ3 - Powered, awake, filter reset low: normal mode, modulator and filter run.
// RQ4 - Powered, awake, filter reset high: modulator on, filter held reset.
// RQ5 - Sleep high: modulator, sensor, buffers off; filter and amplifier on.
// RQ6 - In normal and reset modes the temperature sensor follows channel selects.
// RQ7 - In normal and reset modes each reference buffer follows its enable.
// RQ8 - Completion flag sets at the end of every conversion; here it sets only when a buffered result reaches result_out.
// RQ9 - Interrupt request rises with the flag; interrupt needs both enables.
// RQ10 - Software sets both enables for interrupt-driven use.
// RQ11 - Software polls the flag before reading result bytes.
// RQ12 - Each new result overwrites the result bytes; here a two-entry buffer drops results that finish while full.
// RQ13 - Latch enable holds the latest result, later ones discarded.
// RQ14 - Software picks a divider for a converter clock near 4 MHz.
// RQ15 - Reference select picks internal or external reference pair.
// RQ16 - Software configures everything, releases power, then pulses reset.
// RQ17 - Software keeps stack room for the interrupt.
// RQ18 - Power-off switches all converter circuits off; bandgap and regulator stay on while regulator enable is set.
// RQ19 - Results are 24-bit two's complement, clamped to full scale.
// RQ20 - Software clears the completion flag itself.
// RQ21 - While latched, no interrupt and no flag change.
// RQ22 - Filter reset high aborts the conversion; none starts until low.
// RQ23 - Power-off overrides sleep and filter reset.
`default_nettype none

module dsac_ctrl
  import dsac_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  input  wire logic                    converter_power_off_in,
  input  wire logic                    converter_sleep_sel_in,
  input  wire logic                    filter_reset_ctl_in,
  input  wire logic                    regulator_enable_in,
  input  wire logic                    converter_irq_enable_in,
  input  wire logic                    global_irq_enable_in,
  input  wire logic [DSAC_CKDIV_W-1:0] clock_divider_sel_in,
  input  wire logic                    reference_pair_sel_in,
  input  wire logic [DSAC_CHSEL_W-1:0] positive_channel_sel_in,
  input  wire logic [DSAC_CHSEL_W-1:0] negative_channel_sel_in,
  input  wire logic                    neg_ref_buffer_en_in,
  input  wire logic                    pos_ref_buffer_en_in,
  input  wire logic [DSAC_OSR_W-1:0]   oversample_rate_sel_in,
  input  wire logic [DSAC_CHOP_W-1:0]  clock_chop_sel_in,
  input  wire logic                    result_latch_enable_in,
  input  wire logic                    eoc_clear_in,
  input  wire logic                    irq_flag_clear_in,
  input  wire logic                    modulator_bit_in,
  input  wire logic                    result_ready_in,
  output logic                         modulator_on_out,
  output logic                         filter_run_out,
  output logic                         filter_reset_out,
  output logic                         amplifier_on_out,
  output logic                         temp_sensor_on_out,
  output logic                         neg_ref_buffer_on_out,
  output logic                         pos_ref_buffer_on_out,
  output logic                         bandgap_on_out,
  output logic                         regulator_on_out,
  output logic                         external_ref_sel_out,
  output logic                         converter_clock_en_out,
  output logic                         eoc_flag_out,
  output logic                         irq_request_out,
  output logic                         irq_out,
  output logic [DSAC_RES_W-1:0]        result_out,
  output logic                         result_valid_out,
  output logic                         buffer_ready_out
);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  // Operating mode from the three control bits, power-off first
  function automatic dsac_mode_e decode_mode(input logic off,
                                             input logic slp,
                                             input logic rst);
    if (off) begin
      decode_mode = DSAC_MODE_OFF;
    end else if (slp) begin
      decode_mode = DSAC_MODE_SLEEP;
    end else if (rst) begin
      decode_mode = DSAC_MODE_RESET;
    end else begin
      decode_mode = DSAC_MODE_NORMAL;
    end
  endfunction

  // Channel select routes the temperature sensor
  function automatic logic is_temp(input logic [DSAC_CHSEL_W-1:0] sel);
    is_temp = (sel == DSAC_CH_TEMP);
  endfunction

  // ------------------------------------------------------------------
  // Modulator bit synchroniser
  // ------------------------------------------------------------------
  logic mod_sync1;
  logic mod_sync2;

  // Two stages before any logic reads the pin
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mod_sync1 <= 1'b0;
      mod_sync2 <= 1'b0;
    end else begin
      mod_sync1 <= modulator_bit_in;
      mod_sync2 <= mod_sync1;
    end
  end

  // ------------------------------------------------------------------
  // Mode decode and power outputs
  // ------------------------------------------------------------------
  dsac_mode_e mode;
  logic       powered;
  logic       awake;

  assign mode    = decode_mode(converter_power_off_in,   // RQ23
                               converter_sleep_sel_in,
                               filter_reset_ctl_in);
  assign powered = (mode != DSAC_MODE_OFF);               // RQ18
  assign awake   = (mode == DSAC_MODE_NORMAL) ||
                   (mode == DSAC_MODE_RESET);

  logic next_modulator_on;
  logic next_filter_run;
  logic next_filter_reset;
  logic next_amplifier_on;
  logic next_temp_on;
  logic next_nbuf_on;
  logic next_pbuf_on;
  logic next_bandgap_on;
  logic next_regulator_on;

  // Per-mode power switches
  always_comb begin
    next_modulator_on = awake;                            // RQ3 RQ4 RQ5
    next_filter_run   = (mode == DSAC_MODE_NORMAL) ||
                        (mode == DSAC_MODE_SLEEP);        // RQ3 RQ5
    next_filter_reset = (mode == DSAC_MODE_RESET);        // RQ4
    next_amplifier_on = powered;                          // RQ5 RQ18
    next_temp_on      = awake &&
                        (is_temp(positive_channel_sel_in) ||
                         is_temp(negative_channel_sel_in)); // RQ6
    next_nbuf_on      = awake && neg_ref_buffer_en_in;    // RQ7
    next_pbuf_on      = awake && pos_ref_buffer_en_in;    // RQ7
    next_regulator_on = regulator_enable_in;
    next_bandgap_on   = powered || regulator_enable_in;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      modulator_on_out      <= 1'b0;
      filter_run_out        <= 1'b0;
      filter_reset_out      <= 1'b0;
      amplifier_on_out      <= 1'b0;
      temp_sensor_on_out    <= 1'b0;
      neg_ref_buffer_on_out <= 1'b0;
      pos_ref_buffer_on_out <= 1'b0;
      bandgap_on_out        <= 1'b0;
      regulator_on_out      <= 1'b0;
      external_ref_sel_out  <= 1'b0;
    end else begin
      modulator_on_out      <= next_modulator_on;
      filter_run_out        <= next_filter_run;
      filter_reset_out      <= next_filter_reset;
      amplifier_on_out      <= next_amplifier_on;
      temp_sensor_on_out    <= next_temp_on;
      neg_ref_buffer_on_out <= next_nbuf_on;
      pos_ref_buffer_on_out <= next_pbuf_on;
      bandgap_on_out        <= next_bandgap_on;
      regulator_on_out      <= next_regulator_on;
      external_ref_sel_out  <= reference_pair_sel_in;     // RQ15
    end
  end

  // ------------------------------------------------------------------
  // Converter clock divider
  // ------------------------------------------------------------------
  logic [DSAC_CKDIV_W:0]    mclk_cnt;
  logic [DSAC_CKDIV_W:0]    next_mclk_cnt;
  logic                     mclk_tick;
  logic [DSAC_DIVCNT_W-1:0] adck_cnt;
  logic [DSAC_DIVCNT_W-1:0] next_adck_cnt;
  logic [DSAC_DIVCNT_W-1:0] adck_len;
  logic                     adck_tick;
  logic                     next_clock_en;

  // System clock halved, divided by code+1 (or passed), then to sample rate
  always_comb begin
    mclk_tick     = (clock_divider_sel_in == DSAC_CKDIV_BYPASS) ||
                    (mclk_cnt >= {clock_divider_sel_in, 1'b1});
    next_mclk_cnt = (mclk_tick || !powered) ? '0 :
                    mclk_cnt + 1'b1;
    adck_len      = clock_chop_sel_in[DSAC_CHOP_FAST_BIT] ?
                    DSAC_ADCK_DIV_FAST : DSAC_ADCK_DIV_SLOW;
    adck_tick     = mclk_tick && (adck_cnt >= adck_len - 1'b1);
    next_adck_cnt = adck_cnt;
    if (!powered) begin
      next_adck_cnt = '0;
    end else if (mclk_tick) begin
      next_adck_cnt = adck_tick ? '0 : adck_cnt + 1'b1;
    end
    next_clock_en = powered && mclk_tick;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mclk_cnt               <= '0;
      adck_cnt               <= '0;
      converter_clock_en_out <= 1'b0;
    end else begin
      mclk_cnt               <= next_mclk_cnt;
      adck_cnt               <= next_adck_cnt;
      converter_clock_en_out <= next_clock_en;
    end
  end

  // ------------------------------------------------------------------
  // Conversion sequencer and decimator
  // ------------------------------------------------------------------
  dsac_state_e              state;
  dsac_state_e              next_state;
  logic [DSAC_DECCNT_W-1:0] dec_cnt;
  logic [DSAC_DECCNT_W-1:0] next_dec_cnt;
  logic [DSAC_DECCNT_W-1:0] dec_len;
  logic signed [DSAC_RES_W:0] acc;
  logic signed [DSAC_RES_W:0] next_acc;
  logic signed [DSAC_RES_W:0] acc_sum;
  logic [DSAC_RES_W-1:0]    conv_word;
  logic                     conv_done;

  // Start, abort and finish each conversion
  always_comb begin
    dec_len    = DSAC_DEC_BASE >>
                 ((oversample_rate_sel_in > DSAC_OSR_MAX) ?
                  DSAC_OSR_MAX : oversample_rate_sel_in);
    next_state = state;
    next_dec_cnt = dec_cnt;
    next_acc   = acc;
    conv_done  = 1'b0;
    // Running sum including this sample, so the last one counts too
    acc_sum    = mod_sync2 ? acc + (DSAC_RES_W+1)'(1) :
                 acc - (DSAC_RES_W+1)'(1);
    if (acc_sum > $signed({1'b0, DSAC_RES_MAX})) begin
      conv_word = DSAC_RES_MAX;                           // RQ19
    end else if (acc_sum < $signed({1'b1, DSAC_RES_MIN})) begin
      conv_word = DSAC_RES_MIN;                           // RQ19
    end else begin
      conv_word = acc_sum[DSAC_RES_W-1:0];
    end
    unique case (state)
      DSAC_ST_IDLE: begin
        if (mode == DSAC_MODE_RESET) begin
          next_state = DSAC_ST_ARMED;                     // RQ2
        end
      end
      DSAC_ST_ARMED: begin
        if (mode == DSAC_MODE_NORMAL) begin
          next_state   = DSAC_ST_CONV;                    // RQ2 RQ22
          next_dec_cnt = '0;
          next_acc     = '0;
        end else if (mode != DSAC_MODE_RESET) begin
          next_state = DSAC_ST_IDLE;
        end
      end
      DSAC_ST_CONV: begin
        if (mode == DSAC_MODE_RESET) begin
          next_state = DSAC_ST_ARMED;                     // RQ22
        end else if (mode != DSAC_MODE_NORMAL) begin
          next_state = DSAC_ST_IDLE;                      // RQ18
        end else if (adck_tick) begin
          next_acc = acc_sum;
          if (dec_cnt >= dec_len - 1'b1) begin
            conv_done    = 1'b1;                          // RQ8 RQ12
            next_dec_cnt = '0;
            next_acc     = '0;
          end else begin
            next_dec_cnt = dec_cnt + 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state   <= DSAC_ST_IDLE;
      dec_cnt <= '0;
      acc     <= '0;
    end else begin
      state   <= next_state;
      dec_cnt <= next_dec_cnt;
      acc     <= next_acc;
    end
  end

  // ------------------------------------------------------------------
  // Two-entry result buffer
  // ------------------------------------------------------------------
  logic [DSAC_RES_W-1:0] buf_mem [DSAC_BUF_DEPTH];
  logic                  wr_ptr;
  logic                  rd_ptr;
  logic [1:0]            buf_cnt;
  logic                  buf_push;
  logic                  buf_pop;

  assign buf_push = conv_done && !result_latch_enable_in &&
                    (buf_cnt != 2'(DSAC_BUF_DEPTH));      // RQ13 RQ21
  assign buf_pop  = (buf_cnt != 2'h0) && result_ready_in;

  // Store new results; pop into the output register
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_mem[wr_ptr] <= conv_word;
        wr_ptr          <= ~wr_ptr;
      end
      if (buf_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      buf_cnt <= buf_cnt + 2'(buf_push) - 2'(buf_pop);
    end
  end

  // ------------------------------------------------------------------
  // Result register, completion flag and interrupt
  // ------------------------------------------------------------------
  logic                  next_eoc;
  logic                  next_irq_req;
  logic [DSAC_RES_W-1:0] next_result;

  // Set wins over a same-cycle clear
  always_comb begin
    next_result  = buf_pop ? buf_mem[rd_ptr] : result_out;  // RQ12
    next_eoc     = buf_pop || (eoc_flag_out && !eoc_clear_in); // RQ8
    next_irq_req = buf_pop ||
                   (irq_request_out && !irq_flag_clear_in); // RQ9
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      result_out       <= '0;
      result_valid_out <= 1'b0;
      eoc_flag_out     <= 1'b0;
      irq_request_out  <= 1'b0;
      irq_out          <= 1'b0;
      buffer_ready_out <= 1'b1;
    end else begin
      result_out       <= next_result;
      result_valid_out <= buf_pop;
      eoc_flag_out     <= next_eoc;
      irq_request_out  <= next_irq_req;
      irq_out          <= next_irq_req && converter_irq_enable_in &&
                          global_irq_enable_in;           // RQ9
      buffer_ready_out <= (buf_cnt + 2'(buf_push) - 2'(buf_pop))
                          != 2'(DSAC_BUF_DEPTH);
    end
  end

endmodule : dsac_ctrl

`default_nettype wire

// *** pkg/dsac_pkg.sv ***
// Constants and types for the delta-sigma converter control sequencer.
// Assumes a single 100 MHz system clock domain.
`default_nettype none

package dsac_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int unsigned DSAC_RES_W   = 24;
  localparam int unsigned DSAC_CKDIV_W = 5;
  localparam int unsigned DSAC_OSR_W   = 4;
  localparam int unsigned DSAC_CHOP_W  = 3;
  localparam int unsigned DSAC_CHSEL_W = 4;
  localparam int unsigned DSAC_DIVCNT_W = 6;
  localparam int unsigned DSAC_DECCNT_W = 16;
  localparam int unsigned DSAC_BUF_DEPTH = 2;

  // ------------------------------------------------------------------
  // Encodings and counts
  // ------------------------------------------------------------------
  // Divider code that passes the system clock undivided
  localparam logic [DSAC_CKDIV_W-1:0] DSAC_CKDIV_BYPASS = 5'h1f;
  // Channel-select code that routes the temperature sensor
  localparam logic [DSAC_CHSEL_W-1:0] DSAC_CH_TEMP = 4'hf;
  // Converter clocks per filter sample: divide by 30 or by 12
  localparam logic [DSAC_DIVCNT_W-1:0] DSAC_ADCK_DIV_SLOW = 6'h1e;
  localparam logic [DSAC_DIVCNT_W-1:0] DSAC_ADCK_DIV_FAST = 6'h0c;
  // Bit of the chop field that selects the fast sampling clock
  localparam int unsigned DSAC_CHOP_FAST_BIT = 1;
  // Base decimation length; shifted right by the rate code, capped at DSAC_OSR_MAX
  localparam logic [DSAC_DECCNT_W-1:0] DSAC_DEC_BASE = 16'h8000;
  localparam logic [DSAC_OSR_W-1:0] DSAC_OSR_MAX = 4'h8;
  // Full-scale limits in two's complement
  localparam logic [DSAC_RES_W-1:0] DSAC_RES_MAX = 24'h7fffff;
  localparam logic [DSAC_RES_W-1:0] DSAC_RES_MIN = 24'h800000;

  // Operating modes
  typedef enum logic [1:0] {
    DSAC_MODE_OFF,
    DSAC_MODE_SLEEP,
    DSAC_MODE_NORMAL,
    DSAC_MODE_RESET
  } dsac_mode_e;

  // Conversion sequence
  typedef enum logic [1:0] {
    DSAC_ST_IDLE,
    DSAC_ST_ARMED,
    DSAC_ST_CONV
  } dsac_state_e;

endpackage : dsac_pkg

`default_nettype wire

// *** verif/dsac_ctrl_props.sv ***
// Checker for the converter control sequencer, watching its ports only.
// Assumes one clock domain with a synchronous active-low reset.
`default_nettype none

module dsac_ctrl_props
  import dsac_pkg::*;
(
  input wire logic                    clk_in,
  input wire logic                    rstn_in,
  input wire logic                    converter_power_off_in,
  input wire logic                    converter_sleep_sel_in,
  input wire logic                    filter_reset_ctl_in,
  input wire logic                    converter_irq_enable_in,
  input wire logic                    global_irq_enable_in,
  input wire logic                    reference_pair_sel_in,
  input wire logic [DSAC_CHSEL_W-1:0] positive_channel_sel_in,
  input wire logic [DSAC_CHSEL_W-1:0] negative_channel_sel_in,
  input wire logic                    neg_ref_buffer_en_in,
  input wire logic                    pos_ref_buffer_en_in,
  input wire logic                    result_latch_enable_in,
  input wire logic                    result_ready_in,
  input wire logic                    modulator_on_out,
  input wire logic                    filter_run_out,
  input wire logic                    filter_reset_out,
  input wire logic                    amplifier_on_out,
  input wire logic                    temp_sensor_on_out,
  input wire logic                    neg_ref_buffer_on_out,
  input wire logic                    pos_ref_buffer_on_out,
  input wire logic                    external_ref_sel_out,
  input wire logic                    eoc_flag_out,
  input wire logic                    irq_request_out,
  input wire logic                    irq_out,
  input wire logic                    result_valid_out,
  input wire logic                    buffer_ready_out
);

  // ------------------------------------------------------------------
  // Mode decode helpers
  // ------------------------------------------------------------------
  logic powered;
  logic awake;
  logic temp_pick;
  assign powered   = !converter_power_off_in;
  assign awake     = powered && !converter_sleep_sel_in;
  assign temp_pick = (positive_channel_sel_in == DSAC_CH_TEMP) ||
                     (negative_channel_sel_in == DSAC_CH_TEMP);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // Steps held long enough for the result path to drain
  sequence s_latched;
    (result_latch_enable_in && result_ready_in) [*4];
  endsequence
  sequence s_held_reset;
    (filter_reset_ctl_in && result_ready_in) [*4];
  endsequence

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_off_dark: assert property (converter_power_off_in |=>
    !modulator_on_out && !filter_run_out && !amplifier_on_out &&
    !temp_sensor_on_out && !neg_ref_buffer_on_out && !pos_ref_buffer_on_out)
    else $error("power-off left a circuit on");
  a_sleep_mode: assert property (powered && converter_sleep_sel_in |=>
    !modulator_on_out && filter_run_out && amplifier_on_out &&
    !temp_sensor_on_out && !neg_ref_buffer_on_out && !pos_ref_buffer_on_out)
    else $error("sleep outputs wrong");
  a_normal_mode: assert property (awake && !filter_reset_ctl_in |=>
    modulator_on_out && filter_run_out && !filter_reset_out)
    else $error("normal mode outputs wrong");
  a_reset_mode: assert property (awake && filter_reset_ctl_in |=>
    modulator_on_out && !filter_run_out && filter_reset_out)
    else $error("reset mode outputs wrong");
  a_buf_follow: assert property (awake |=>
    neg_ref_buffer_on_out == $past(neg_ref_buffer_en_in) &&
    pos_ref_buffer_on_out == $past(pos_ref_buffer_en_in))
    else $error("reference buffer not following enable");
  a_temp_select: assert property (awake |=>
    temp_sensor_on_out == $past(temp_pick))
    else $error("sensor not following channel selects");
  a_ref_select: assert property (powered |=>
    external_ref_sel_out == $past(reference_pair_sel_in))
    else $error("reference pair select not followed");
  a_flag_with_result: assert property (result_valid_out |->
    eoc_flag_out && irq_request_out)
    else $error("result without completion flags");
  a_irq_gate: assert property (1'b1 |-> irq_out ==
    (irq_request_out &&
     $past(converter_irq_enable_in && global_irq_enable_in)))
    else $error("interrupt not gated by both enables");
  a_latch_quiet: assert property (s_latched |->
    !result_valid_out && !$rose(eoc_flag_out))
    else $error("result delivered while latched");
  a_abort_quiet: assert property (s_held_reset |-> !result_valid_out)
    else $error("result delivered while filter held in reset");
  a_full_stall: assert property (
    !buffer_ready_out && !result_ready_in |=>
    !result_valid_out && !buffer_ready_out)
    else $error("word popped while consumer stalled");

endmodule // dsac_ctrl_props

bind dsac_ctrl dsac_ctrl_props dsac_ctrl_props_inst (.*);

`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the converter control sequencer.
// Assumes the checker is bound to the design from its own file.
`default_nettype none

module testbench;
  import dsac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_in = 1'b0, rstn_in = 1'b0;
  logic        off = 1'b1, slp = 1'b0, frst = 1'b0, reg_en = 1'b0;
  logic        cie = 1'b0, gie = 1'b0, refsel = 1'b0, nen = 1'b0;
  logic        pen = 1'b0, latch = 1'b0, eoc_clr = 1'b0, irq_clr = 1'b0;
  logic        mod_bit = 1'b0, rdy = 1'b1;
  logic [3:0]  psel = 4'h0, nsel = 4'h0;
  logic [4:0]  ckdiv = DSAC_CKDIV_BYPASS;
  logic        mod_on, f_run, f_rst, amp_on, t_on, nb_on, pb_on, bg_on;
  logic        reg_on, ext_ref, eoc, irq_req, irq, res_v, buf_rdy, ck_en;
  logic [23:0] res;
  int          err_count = 0;
  int          checks_done = 0;
  int          n_en = 0;

  // Clock at 100 MHz
  always #5 clk_in = ~clk_in;

  // Divider bypassed, shortest decimation, fast sampling clock
  dsac_ctrl dsac_ctrl_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .converter_power_off_in(off), .converter_sleep_sel_in(slp),
    .filter_reset_ctl_in(frst), .regulator_enable_in(reg_en),
    .converter_irq_enable_in(cie), .global_irq_enable_in(gie),
    .clock_divider_sel_in(ckdiv),
    .reference_pair_sel_in(refsel), .positive_channel_sel_in(psel),
    .negative_channel_sel_in(nsel), .neg_ref_buffer_en_in(nen),
    .pos_ref_buffer_en_in(pen), .oversample_rate_sel_in(DSAC_OSR_MAX),
    .clock_chop_sel_in(3'h2), .result_latch_enable_in(latch),
    .eoc_clear_in(eoc_clr), .irq_flag_clear_in(irq_clr),
    .modulator_bit_in(mod_bit), .result_ready_in(rdy),
    .modulator_on_out(mod_on), .filter_run_out(f_run),
    .filter_reset_out(f_rst), .amplifier_on_out(amp_on),
    .temp_sensor_on_out(t_on), .neg_ref_buffer_on_out(nb_on),
    .pos_ref_buffer_on_out(pb_on), .bandgap_on_out(bg_on),
    .regulator_on_out(reg_on), .external_ref_sel_out(ext_ref),
    .converter_clock_en_out(ck_en), .eoc_flag_out(eoc),
    .irq_request_out(irq_req), .irq_out(irq), .result_out(res),
    .result_valid_out(res_v), .buffer_ready_out(buf_rdy));

  // ------------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a delivered word, then its value
  task automatic wait_result(input logic [23:0] exp);
    int n;
    n = 0;
    while (res_v !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    cmp_val({23'h0, res_v}, 24'h1);
    cmp_val(res, exp);
  endtask

  // Counts delivered words over a span; none are expected
  task automatic expect_none(input int n);
    int c;
    c = 0;
    repeat (n) begin
      tick(1);
      if (res_v === 1'b1) c++;
    end
    cmp_val(c[23:0], 24'h0);
  endtask

  task automatic clear_flags();
    eoc_clr = 1'b1;
    irq_clr = 1'b1;
    tick(1);
    eoc_clr = 1'b0;
    irq_clr = 1'b0;
    tick(2);
  endtask

  // Power outputs {mod,run,frst,amp,temp,nbuf,pbuf,bandgap,regulator}
  function automatic logic [8:0] exp_pw(input logic [2:0] m,
      input logic r, input logic n, input logic p, input logic t);
    if (m[2]) return {7'h0, r, r};
    if (m[1]) return {7'b0101000, 1'b1, r};
    if (m[0]) return {4'b1011, t, n, p, 1'b1, r};
    return {4'b1101, t, n, p, 1'b1, r};
  endfunction

  task automatic give_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog on the whole run
  initial begin
    #400_000;
    err_count++;
    give_verdict();
  end

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    tick(12);
    rstn_in = 1'b1;
    tick(1);
    cmp_val({19'h0, eoc, irq_req, irq, res_v, buf_rdy}, 24'h1);
    // Every mode, power-off overriding sleep and filter reset
    for (int i = 0; i < 8; i++) begin
      {off, slp, frst} = i[2:0];
      reg_en = i[0] ^ i[1];
      nen = i[0];
      pen = !i[0];
      refsel = i[1];
      psel = i[1] ? DSAC_CH_TEMP : 4'h0;
      nsel = (i == 1) ? DSAC_CH_TEMP : 4'h0;
      tick(2);
      cmp_val({15'h0, mod_on, f_run, f_rst, amp_on, t_on, nb_on, pb_on,
        bg_on, reg_on}, {15'h0, exp_pw(i[2:0], reg_en, nen, pen,
        i == 1)});
      if (!i[2]) cmp_val({23'h0, ext_ref}, {23'h0, refsel});
    end
    // Start by a reset pulse, interrupt fully enabled
    {off, slp, frst} = 3'b001;
    mod_bit = 1'b1;
    cie = 1'b1;
    gie = 1'b1;
    tick(2);
    frst = 1'b0;
    wait_result(24'h000080);
    cmp_val({22'h0, eoc, irq_req}, 24'h3);
    tick(1);
    cmp_val({23'h0, irq}, 24'h1);
    clear_flags();
    cmp_val({21'h0, eoc, irq_req, irq}, 24'h0);
    // Abort mid conversion, restart with the opposite polarity
    mod_bit = 1'b0;
    gie = 1'b0;
    frst = 1'b1;
    expect_none(2000);
    frst = 1'b0;
    wait_result(24'hffff80);
    tick(1);
    cmp_val({21'h0, eoc, irq_req, irq}, 24'h6);
    // Latched result survives later conversions
    clear_flags();
    latch = 1'b1;
    mod_bit = 1'b1;
    expect_none(3500);
    cmp_val({23'h0, eoc}, 24'h0);
    cmp_val(res, 24'hffff80);
    latch = 1'b0;
    wait_result(24'h000080);
    // Consumer stalls until the buffer is full, then drains it
    rdy = 1'b0;
    expect_none(3300);
    cmp_val({23'h0, buf_rdy}, 24'h0);
    rdy = 1'b1;
    wait_result(24'h000080);
    tick(1);
    wait_result(24'h000080);
    tick(2);
    cmp_val({23'h0, buf_rdy}, 24'h1);
    // Undivided: a tick every cycle; code 1: halved then by two
    cmp_val({23'h0, ck_en}, 24'h1);
    ckdiv = 5'h01;
    repeat (40) begin
      tick(1);
      if (ck_en === 1'b1) n_en++;
    end
    cmp_val(n_en[23:0], 24'h00000a);
    give_verdict();
  end

endmodule // testbench

`default_nettype wire
